// ==== rtl/cmpirq_defs.svh ====
// cmpirq_defs.svh: offsets, field positions and reset values of the
// second comparator's mode register and control bits.
// assumes: included by the package and the control-register file by bare name.
`ifndef CMPIRQ_DEFS_SVH
`define CMPIRQ_DEFS_SVH

`define CMPIRQ_MODE_ADDR 8'h89
`define CMPIRQ_CTRL_ADDR 8'h88
`define CMPIRQ_MODE_RESET 8'h02
`define CMPIRQ_MODE_WMASK 8'h33
`define CMPIRQ_CTRL_RESET 8'h00
`define CMPIRQ_RISE_IE_BIT 5
`define CMPIRQ_FALL_IE_BIT 4
`define CMPIRQ_ENABLE_BIT 7
`define CMPIRQ_OUT_BIT 6
`define CMPIRQ_RISE_FLAG_BIT 5
`define CMPIRQ_FALL_FLAG_BIT 4
`define CMPIRQ_CTRL_WMASK 8'hbf
`define CMPIRQ_RESP_MSB 1
`define CMPIRQ_RESP_LSB 0
`define CMPIRQ_HYST_MSB 3
`define CMPIRQ_HYST_LSB 0

`endif

// ==== rtl/cmpirq_pkg.sv ====
// cmpirq_pkg: types shared by the comparator control files.
// assumes: the defines header is on the include path.
`default_nettype none
`include "cmpirq_defs.svh"

package cmpirq_pkg;

  // special-function-register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cmpirq_sfr_s;

  // response mode select
  typedef enum logic [1:0] {
    CMPIRQ_FASTEST,
    CMPIRQ_MODE1,
    CMPIRQ_MODE2,
    CMPIRQ_LOW_POWER
  } cmpirq_resp_e;

  // detected transitions of the comparator output
  typedef struct packed {
    logic rise;
    logic fall;
  } cmpirq_edge_s;

endpackage : cmpirq_pkg

`default_nettype wire

// ==== rtl/cmpirq_edge_sync.sv ====
// cmpirq_edge_sync: synchronises the analog comparator output and
// detects its edges while the comparator is enabled.
// assumes: raw output is asynchronous to i_ref_clk.
`default_nettype none

module cmpirq_edge_sync
  import cmpirq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_raw,
  input wire logic i_enable,
  output logic o_level,
  output cmpirq_edge_s o_edge
);

  logic sync_a;
  logic sync_b;
  logic prev;

  // two-flop synchroniser; sync_a feeds only sync_b
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= i_raw;
      sync_b <= sync_a;
    end
  end

  // disabled comparator reads low, so no edges are seen then
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prev <= 1'b0;
    end else begin
      prev <= sync_b & i_enable;
    end
  end

  assign o_level = sync_b & i_enable;
  assign o_edge.rise = o_level & ~prev;
  assign o_edge.fall = ~o_level & prev & i_enable;

endmodule : cmpirq_edge_sync

`default_nettype wire

// ==== rtl/cmpirq_ctrl.sv ====
// cmpirq_ctrl: mode and control registers of the second comparator,
// edge flags and interrupt request.
// assumes: one-cycle read/write strobes from the core's register bus.
`default_nettype none
`include "cmpirq_defs.svh"

// Operation
// - mode bits 7-6 read zero, writes ignored
// - mode bits 3-2 read zero, writes ignored
// - bit 5 enables rising-edge interrupt
// - bit 4 enables falling-edge interrupt
// - bits 1-0 select response mode
// - mode register resets to 0x02
// - edge flags set on edges, software clears
// - disabled comparator: output low, no interrupts
// - no reset-source path from this comparator
module cmpirq_ctrl
  import cmpirq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire cmpirq_sfr_s i_sfr,
  input wire logic i_cmp_raw,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_pin_out,
  output cmpirq_resp_e o_resp_mode,
  output logic o_cmp_enable
);

  // reset and write-mask images as vectors: fields are picked out of
  // them by position, which a bare macro literal does not allow
  localparam logic [7:0] MODE_RESET = `CMPIRQ_MODE_RESET;
  localparam logic [7:0] MODE_WMASK = `CMPIRQ_MODE_WMASK;
  localparam logic [7:0] CTRL_RESET = `CMPIRQ_CTRL_RESET;
  localparam logic [7:0] CTRL_WMASK = `CMPIRQ_CTRL_WMASK;

  // mode register fields
  logic rise_irq_enable;
  logic fall_irq_enable;
  cmpirq_resp_e resp_mode;
  // control register fields
  logic comparator_enable;
  logic rise_edge_flag;
  logic fall_edge_flag;
  logic [3:0] hyst;
  // synchronised comparator level and its edges
  logic comparator_output_state;
  cmpirq_edge_s edges;
  // bus decode
  logic mode_sel;
  logic ctrl_sel;
  logic wr_mode;
  logic wr_ctrl;
  logic [7:0] mode_wdata;
  logic [7:0] ctrl_wdata;
  // register images as software reads them
  logic [7:0] mode_image;
  logic [7:0] ctrl_image;
  logic [7:0] next_rdata;
  // interrupt causes
  logic rise_cause;
  logic fall_cause;
  logic next_irq;

  // address decode; a strobe to any other address touches nothing here
  assign mode_sel = (i_sfr.addr == `CMPIRQ_MODE_ADDR);
  assign ctrl_sel = (i_sfr.addr == `CMPIRQ_CTRL_ADDR);
  assign wr_mode = i_sfr.wr && mode_sel;
  assign wr_ctrl = i_sfr.wr && ctrl_sel;

  // unused and read-only bits are masked off before they reach a flop
  assign mode_wdata = i_sfr.wdata & MODE_WMASK;
  assign ctrl_wdata = i_sfr.wdata & CTRL_WMASK;

  // raw comparator level: synchronised, gated by enable, edge detected
  cmpirq_edge_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_raw(i_cmp_raw),
    .i_enable(comparator_enable),
    .o_level(comparator_output_state),
    .o_edge(edges)
  );

  // rising-edge interrupt enable
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rise_irq_enable <= MODE_RESET[`CMPIRQ_RISE_IE_BIT];
    end else if (wr_mode) begin
      rise_irq_enable <= mode_wdata[`CMPIRQ_RISE_IE_BIT];
    end
  end

  // falling-edge interrupt enable
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fall_irq_enable <= MODE_RESET[`CMPIRQ_FALL_IE_BIT];
    end else if (wr_mode) begin
      fall_irq_enable <= mode_wdata[`CMPIRQ_FALL_IE_BIT];
    end
  end

  // response mode; every 2-bit code is a legal mode
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      resp_mode <= cmpirq_resp_e'(MODE_RESET[1:0]);
    end else if (wr_mode) begin
      resp_mode <= cmpirq_resp_e'(mode_wdata[1:0]);
    end
  end

  // comparator enable
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      comparator_enable <= CTRL_RESET[`CMPIRQ_ENABLE_BIT];
    end else if (wr_ctrl) begin
      comparator_enable <= ctrl_wdata[`CMPIRQ_ENABLE_BIT];
    end
  end

  // hysteresis setting: stored and read back only; no port carries it to the analog side
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hyst <= CTRL_RESET[3:0];
    end else if (wr_ctrl) begin
      hyst <= ctrl_wdata[3:0];
    end
  end

  // sticky rising-edge flag; an edge in the clearing cycle wins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rise_edge_flag <= CTRL_RESET[`CMPIRQ_RISE_FLAG_BIT];
    end else if (edges.rise) begin
      rise_edge_flag <= 1'b1;
    end else if (wr_ctrl) begin
      rise_edge_flag <= ctrl_wdata[`CMPIRQ_RISE_FLAG_BIT];
    end
  end

  // sticky falling-edge flag; an edge in the clearing cycle wins
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fall_edge_flag <= CTRL_RESET[`CMPIRQ_FALL_FLAG_BIT];
    end else if (edges.fall) begin
      fall_edge_flag <= 1'b1;
    end else if (wr_ctrl) begin
      fall_edge_flag <= ctrl_wdata[`CMPIRQ_FALL_FLAG_BIT];
    end
  end

  // each cause needs its flag and its enable
  assign rise_cause = rise_edge_flag && rise_irq_enable;
  assign fall_cause = fall_edge_flag && fall_irq_enable;
  // a disabled comparator raises no request, whatever the flags hold
  assign next_irq = comparator_enable && (rise_cause || fall_cause);

  // registered request; this comparator has no reset-source output
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end

  // mode image; unused fields are tied to zero, not stored
  always_comb begin
    mode_image = 8'h00;
    mode_image[`CMPIRQ_RISE_IE_BIT] = rise_irq_enable;
    mode_image[`CMPIRQ_FALL_IE_BIT] = fall_irq_enable;
    mode_image[`CMPIRQ_RESP_MSB:`CMPIRQ_RESP_LSB] = resp_mode;
  end

  // control image; the output state bit shows the gated level
  always_comb begin
    ctrl_image = 8'h00;
    ctrl_image[`CMPIRQ_ENABLE_BIT] = comparator_enable;
    ctrl_image[`CMPIRQ_OUT_BIT] = comparator_output_state;
    ctrl_image[`CMPIRQ_RISE_FLAG_BIT] = rise_edge_flag;
    ctrl_image[`CMPIRQ_FALL_FLAG_BIT] = fall_edge_flag;
    ctrl_image[`CMPIRQ_HYST_MSB:`CMPIRQ_HYST_LSB] = hyst;
  end

  // read mux; zero when no read or for any other address
  always_comb begin
    next_rdata = 8'h00;
    if (i_sfr.rd && mode_sel) begin
      next_rdata = mode_image;
    end else if (i_sfr.rd && ctrl_sel) begin
      next_rdata = ctrl_image;
    end
  end

  // read data stands for the one cycle after the read strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // port pin copy of the comparator, low while disabled
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out <= 1'b0;
    end else begin
      o_pin_out <= comparator_output_state;
    end
  end

  // response mode to the analog side
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_resp_mode <= cmpirq_resp_e'(MODE_RESET[1:0]);
    end else begin
      o_resp_mode <= resp_mode;
    end
  end

  // enable to the analog side
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmp_enable <= CTRL_RESET[`CMPIRQ_ENABLE_BIT];
    end else begin
      o_cmp_enable <= comparator_enable;
    end
  end

endmodule : cmpirq_ctrl

`default_nettype wire

// ==== tb/cmpirq_assertions.sv ====
// checker: comparator control ports
// assumes: bound below
`default_nettype none
module cmpirq_chk
  import cmpirq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic o_irq,
  input wire logic o_pin_out,
  input wire logic o_cmp_enable,
  input wire cmpirq_sfr_s i_sfr,
  input wire logic [7:0] o_rdata,
  input wire cmpirq_resp_e o_resp_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // read decodes
  wire logic m = i_sfr.rd && i_sfr.addr == 8'h89;
  wire logic c = i_sfr.rd && i_sfr.addr == 8'h88;
  hi_zero_a: assert property ($past(m) |-> !o_rdata[7:6])
    else $error("bits 7-6");
  mid_zero_a: assert property ($past(m) |-> !o_rdata[3:2])
    else $error("bits 3-2");
  // a write reaches the registered outputs two edges later
  resp_wr_a: assert property (i_sfr.wr && i_sfr.addr == 8'h89 |=>
    ##1 o_resp_mode == $past(i_sfr.wdata[1:0], 2)) else $error("mode");
  en_wr_a: assert property (i_sfr.wr && i_sfr.addr == 8'h88 |=>
    ##1 o_cmp_enable == $past(i_sfr.wdata[7], 2)) else $error("enable");
  irq_off_a: assert property (!o_cmp_enable [*2] |-> !o_irq)
    else $error("irq");
  pin_low_a: assert property (!o_cmp_enable [*2] |-> !o_pin_out)
    else $error("pin");
  ctrl_rd_a: assert property ($past(c) |->
    o_rdata[7] == o_cmp_enable) else $error("bit 7");
  rd_idle_a: assert property (!$past(i_sfr.rd) |-> !o_rdata)
    else $error("idle data");
endmodule : cmpirq_chk
bind cmpirq_ctrl cmpirq_chk u_chk (.*);
`default_nettype wire

// ==== tb/tb.sv ====
// tb: tests of the comparator control block
// assumes: rtl files compiled first
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb
  import cmpirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_cmp_raw = 1'b0;
  logic o_irq, o_pin_out, o_cmp_enable;
  logic [7:0] o_rdata;
  cmpirq_sfr_s i_sfr = '0;
  cmpirq_resp_e o_resp_mode;
  int fails, samples_checked;
  // written, read back
  logic [15:0] rows [4] = '{16'hff33, 16'hcc00, 16'h2121, 16'h1212};
  cmpirq_ctrl DUT (.*);
  // clock
  initial forever #20 i_ref_clk = ~i_ref_clk;
  // one bus access
  task automatic acc(logic w, logic [7:0] a, d);
    @(negedge i_ref_clk);
    i_sfr = '{a, w, !w, d};
    @(negedge i_ref_clk);
    i_sfr = '{a, 1'b0, 1'b0, d};
    if (!w) `CHK("rdata", d, o_rdata)
  endtask : acc
  // edge check
  task automatic lvl(logic raw, irq, pin);
    i_cmp_raw = raw;
    repeat (6) @(negedge i_ref_clk);
    `CHK("irq", irq, o_irq)
    `CHK("pin", pin, o_pin_out)
  endtask : lvl
  task automatic conclude();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // tests
  initial begin
    repeat (12) @(negedge i_ref_clk);
    i_rst = 1'b0;
    foreach (rows[i]) begin
      acc(1, 8'h89, rows[i][15:8]);
      acc(0, 8'h89, rows[i][7:0]);
      `CHK("mode", rows[i][1:0], o_resp_mode)
    end
    $display("table end");
    acc(1, 8'h88, 8'h80);
    acc(1, 8'h89, 8'h20);
    lvl(1, 1, 1);
    `CHK("enable", 1'b1, o_cmp_enable)
    acc(0, 8'h88, 8'he0);
    acc(1, 8'h88, 8'h80);
    lvl(0, 0, 0);
    acc(1, 8'h89, 8'h10);
    lvl(0, 1, 0);
    acc(1, 8'h88, 8'h10);
    lvl(1, 0, 0);
    `CHK("enable", 1'b0, o_cmp_enable)
    $display("edges end");
    i_rst = 1'b1;
    @(negedge i_ref_clk);
    i_rst = 1'b0;
    acc(0, 8'h89, 8'h02);
    `CHK("mode", 2'h2, o_resp_mode)
    $display("reset end");
    conclude();
  end
  // watchdog
  initial begin
    #40000 fails++;
    conclude();
  end
endmodule : tb
`default_nettype wire
